// >>> mem_space_decoder.sv
// Memory space decoder: maps core addresses to internal ROM, RAM, register area or external.
module mem_space_decoder
(
	mem_map_if.decoder bus,
	input wire logic mclk,
	input wire logic reset,
	input wire logic fast_fetch_enable,
	input wire logic expansion_mode_control,
	input wire logic ext_wait_on_rom,
	output logic in_base,
	output logic in_vector,
	output logic in_table,
	output logic in_fixed_area_call_op,
	output logic in_short,
	output logic in_gpr,
	output logic in_msc,
	output logic is_fixed_vector,
	output logic lockup
);
	import mem_map_pkg::*;

	logic placed_reg;
	logic high_reg;
	logic fast_reg;
	logic lock_reg;
	logic in_data;
	logic in_bank;
	logic in_sfr_win;
	logic in_xsfr_win;
	logic in_short_win;
	logic in_gpr_win;
	logic in_msc_win;
	logic in_table_win;
	logic in_fixed_area_call_op_win;
	logic is_vec_slot;
	logic [15:0] low16;
	target_t tgt_next;
	speed_t spd_next;

	////////////////////////////////////////////////////////////////////////
	// Placement is taken from the first request only; later ones are ignored.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			placed_reg <= placed_reset;
			high_reg <= 1'b0;
		end
		else if (!placed_reg && (bus.place_data_low || bus.place_data_high))
		begin
			placed_reg <= 1'b1;
			high_reg <= bus.place_data_high && !bus.place_data_low;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			fast_reg <= fast_fetch_reset;
		else
			fast_reg <= fast_fetch_enable;
	end

	// Only reset leaves the lock, so a misprogrammed wait is a hard hang.
	always_ff @(posedge mclk)
	begin
		if (reset)
			lock_reg <= 1'b0;
		else if (bus.req && tgt_next == tgt_rom && ext_wait_on_rom)
			lock_reg <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Window decode: one flag per address range, all taken from the current address.
	// Before any placement the low map applies, so early vector reads still find ROM.
	always_comb
	begin
		low16 = bus.addr[15:0];
		in_bank = high_reg ? (bus.addr[19:16] == high_offset[19:16])
			: (bus.addr[19:16] == 4'h0);
		in_data = in_bank && (low16 >= peripheral_ram_start);
		in_sfr_win = low16 >= sfr_start;
		in_xsfr_win = low16 >= xsfr_start && low16 <= xsfr_end;
		in_short_win = in_data && low16 >= short_start && low16 <= fast_internal_ram_end;
		in_gpr_win = in_data && low16 >= gpr_start && low16 <= fast_internal_ram_end;
		in_msc_win = in_data && low16 >= msc_start && low16 <= msc_end;
		in_table_win = bus.addr >= table_start && bus.addr <= table_end;
		in_fixed_area_call_op_win = bus.addr >= fixed_area_call_op_start && bus.addr <= fixed_area_call_op_end;
		is_vec_slot = bus.addr[19:16] == 4'h0 && (low16 == vec_break
			|| low16 == vec_trap || low16 == vec_nmi || low16 == vec_wdt);
	end

	// Target and fetch speed; the data area is tested first so it wins overlaps.
	// A fetch into the fast RAM or register area is acknowledged with the fault flag set.
	always_comb
	begin
		tgt_next = tgt_ext;
		if (in_data)
		begin
			if (in_sfr_win)
				tgt_next = in_xsfr_win
					? (expansion_mode_control ? tgt_xsfr : tgt_none) : tgt_sfr;
			else if (low16 >= fast_internal_ram_start)
				tgt_next = tgt_fast_internal_ram;
			else
				tgt_next = tgt_peripheral_ram;
		end
		else if (bus.addr <= rom_top)
			tgt_next = tgt_rom;
		else if (!expansion_mode_control)
			tgt_next = tgt_none;
		spd_next = spd_slow;
		if (bus.fetch)
		begin
			case (tgt_next)
				tgt_rom: spd_next = fast_reg ? spd_fast : spd_slow;
				tgt_peripheral_ram: spd_next = spd_fast;
				tgt_fast_internal_ram, tgt_sfr, tgt_xsfr: spd_next = spd_bad;
				default: spd_next = spd_slow;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The answer stands one cycle and follows the request every cycle while the lock is clear.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			bus.ack <= 1'b0;
			bus.target <= tgt_none;
			bus.speed <= spd_slow;
			bus.fault <= 1'b0;
		end
		else
		begin
			bus.ack <= bus.req && !lock_reg;
			bus.target <= tgt_next;
			bus.speed <= spd_next;
			bus.fault <= bus.req && (spd_next == spd_bad || tgt_next == tgt_none);
		end
	end

	// Address classes follow the address by one cycle, in step with the answer.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			in_base <= 1'b0;
			in_vector <= 1'b0;
			in_table <= 1'b0;
			in_fixed_area_call_op <= 1'b0;
			in_short <= 1'b0;
			in_gpr <= 1'b0;
			in_msc <= 1'b0;
			is_fixed_vector <= 1'b0;
		end
		else
		begin
			in_base <= bus.addr <= base_end;
			in_vector <= bus.addr <= vector_end;
			in_table <= in_table_win;
			in_fixed_area_call_op <= in_fixed_area_call_op_win;
			in_short <= in_short_win;
			in_gpr <= in_gpr_win;
			in_msc <= in_msc_win;
			is_fixed_vector <= is_vec_slot;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			bus.placed <= 1'b0;
			bus.placed_high <= 1'b0;
			lockup <= 1'b0;
		end
		else
		begin
			bus.placed <= placed_reg;
			bus.placed_high <= high_reg;
			lockup <= lock_reg;
		end
	end
endmodule

// >>> mem_map_pkg.sv
// Package with the memory map constants shared by the core end and the decoder.
package mem_map_pkg;
	localparam int addr_w = 20;
	localparam logic [19:0] rom_low_end = 20'h0ccff;
	localparam logic [19:0] rom_hi_start = 20'h10000;
	localparam logic [19:0] rom_top = 20'h3ffff;
	localparam logic [19:0] base_end = 20'h0ffff;
	localparam logic [19:0] vector_end = 20'h0003f;
	localparam logic [19:0] table_start = 20'h00040;
	localparam logic [19:0] table_end = 20'h0007f;
	localparam int table_entries = 32;
	localparam logic [19:0] fixed_area_call_op_start = 20'h00800;
	localparam logic [19:0] fixed_area_call_op_end = 20'h00fff;
	localparam logic [19:0] high_offset = 20'hf0000;
	localparam logic [15:0] peripheral_ram_start = 16'hcd00;
	localparam logic [15:0] fast_internal_ram_start = 16'hfd00;
	localparam logic [15:0] fast_internal_ram_end = 16'hfeff;
	localparam logic [15:0] short_start = 16'hfd20;
	localparam logic [15:0] gpr_start = 16'hfe80;
	localparam logic [15:0] msc_start = 16'hfe06;
	localparam logic [15:0] msc_end = 16'hfe3b;
	localparam logic [15:0] sfr_start = 16'hff00;
	localparam logic [15:0] xsfr_start = 16'hffd0;
	localparam logic [15:0] xsfr_end = 16'hffdf;
	localparam logic [15:0] vec_break = 16'h003e;
	localparam logic [15:0] vec_trap = 16'h003c;
	localparam logic [15:0] vec_nmi = 16'h0002;
	localparam logic [15:0] vec_wdt = 16'h0004;
	localparam logic fast_fetch_reset = 1'b0;
	localparam logic placed_reset = 1'b0;
	typedef enum logic [2:0] {
		tgt_none = 3'b000,
		tgt_rom = 3'b001,
		tgt_peripheral_ram = 3'b010,
		tgt_fast_internal_ram = 3'b011,
		tgt_sfr = 3'b100,
		tgt_xsfr = 3'b101,
		tgt_ext = 3'b110
	} target_t;
	typedef enum logic [1:0] {
		spd_slow = 2'b00,
		spd_fast = 2'b01,
		spd_bad = 2'b10
	} speed_t;
endpackage

// >>> mem_map_if.sv
// Interface joining the core's access port and the memory space decoder.
interface mem_map_if;
	import mem_map_pkg::*;
	logic req;
	logic fetch;
	logic [19:0] addr;
	logic place_data_low;
	logic place_data_high;
	logic ack;
	target_t target;
	speed_t speed;
	logic fault;
	logic placed_high;
	logic placed;
	modport core (output req, fetch, addr, place_data_low, place_data_high,
		input ack, target, speed, fault, placed_high, placed);
	modport decoder (input req, fetch, addr, place_data_low, place_data_high,
		output ack, target, speed, fault, placed_high, placed);
endinterface

// >>> core_access_port.sv
// Core end: issues placement once after reset, then registered access requests.
module core_access_port
(
	mem_map_if.core bus,
	input wire logic mclk,
	input wire logic reset,
	input wire logic want_high,
	input wire logic user_req,
	input wire logic user_fetch,
	input wire logic [19:0] user_addr,
	output logic done,
	output mem_map_pkg::target_t done_target,
	output logic done_fault
);
	import mem_map_pkg::*;

	logic issued_reg;

	////////////////////////////////////////////////////////////////////////
	// Placement is the first act after reset and is never issued again.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			issued_reg <= 1'b0;
			bus.place_data_low <= 1'b0;
			bus.place_data_high <= 1'b0;
		end
		else
		begin
			issued_reg <= 1'b1;
			bus.place_data_low <= !issued_reg && !want_high;
			bus.place_data_high <= !issued_reg && want_high;
		end
	end

	// Fetches aimed at high-speed RAM or registers complete here with done_fault set.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			bus.req <= 1'b0;
			bus.fetch <= 1'b0;
			bus.addr <= 20'h00000;
			done <= 1'b0;
			done_target <= tgt_none;
			done_fault <= 1'b0;
		end
		else
		begin
			bus.req <= user_req && issued_reg;
			bus.fetch <= user_fetch;
			bus.addr <= user_addr;
			done <= bus.ack;
			done_target <= bus.target;
			done_fault <= bus.fault || bus.speed == spd_bad;
		end
	end
endmodule

// >>> mem_map_asserts.sv
// Concurrent checks on the signals between the core end and the decoder.
module mem_map_asserts
(
	input logic mclk,
	input logic reset,
	input logic req,
	input logic fetch,
	input logic [19:0] addr,
	input logic ack,
	input mem_map_pkg::target_t target,
	input mem_map_pkg::speed_t speed,
	input logic fault,
	input logic placed_high,
	input logic placed
);
	timeunit 1ns;
	timeprecision 1ns;
	import mem_map_pkg::*;
	logic lo;
	logic pr;
	assign lo = placed && !placed_high;
	assign pr = addr[15:0] >= peripheral_ram_start && addr[15:0] < fast_internal_ram_start;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_idle_no_ack: assert property (!req |=> !ack) else $error("ack without request");
	chk_rom_low: assert property (req && lo && addr <= rom_low_end
		|=> !ack || target == tgt_rom) else $error("low rom miss");
	chk_data_wins: assert property (req && lo && addr[19:16] == 4'h0 && pr
		|=> !ack || target == tgt_peripheral_ram) else $error("data area lost");
	chk_high_rom: assert property (req && placed_high && addr <= rom_top
		|=> !ack || target == tgt_rom) else $error("high rom miss");
	chk_high_ram: assert property (req && placed_high && addr[19:16] == 4'hf && pr
		|=> !ack || target == tgt_peripheral_ram) else $error("high ram miss");
	chk_fast_internal_ram_fetch: assert property (req && fetch && lo && addr >= fast_internal_ram_start
		&& addr <= fast_internal_ram_end |=> !ack || fault) else $error("fast_internal_ram fetch allowed");
	chk_sfr_area: assert property (req && lo && addr >= sfr_start && addr <= base_end
		&& !(addr >= xsfr_start && addr <= xsfr_end) |=> !ack || target == tgt_sfr)
		else $error("sfr miss");
	chk_peripheral_ram_fast: assert property (req && fetch && lo && addr[19:16] == 4'h0 && pr
		|=> !ack || speed == spd_fast) else $error("slow peripheral_ram fetch");
	chk_place_lock: assert property (placed |=> placed && $stable(placed_high))
		else $error("placement changed");
endmodule

// >>> memory_space_decoder_tb.sv
// Testbench joining the core end and the decoder and checking decoded accesses.
module memory_space_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mem_map_pkg::*;
	logic mclk = 0, reset = 1, want_high = 0, user_req = 0, user_fetch = 0;
	logic fast = 0, expand = 0, xwait = 0, done, done_fault, lockup;
	logic [19:0] user_addr = 20'h0;
	wire [7:0] cls;
	target_t done_target;
	int failures = 0, comparisons = 0, cyc = 0;
	mem_map_if mif();
	core_access_port u_core_access_port(.bus(mif.core), .mclk(mclk), .reset(reset),
		.want_high(want_high), .user_req(user_req), .user_fetch(user_fetch),
		.user_addr(user_addr), .done(done), .done_target(done_target), .done_fault(done_fault));
	mem_space_decoder u_mem_space_decoder(.bus(mif.decoder), .mclk(mclk), .reset(reset),
		.fast_fetch_enable(fast), .expansion_mode_control(expand), .ext_wait_on_rom(xwait),
		.in_base(cls[7]), .in_vector(cls[6]), .in_table(cls[5]), .in_fixed_area_call_op(cls[4]),
		.in_short(cls[3]), .in_gpr(cls[2]), .in_msc(cls[1]), .is_fixed_vector(cls[0]),
		.lockup(lockup));
	mem_map_asserts u_mem_map_asserts(.mclk(mclk), .reset(reset), .req(mif.req),
		.fetch(mif.fetch), .addr(mif.addr), .ack(mif.ack), .target(mif.target),
		.speed(mif.speed), .fault(mif.fault), .placed_high(mif.placed_high), .placed(mif.placed));
	initial forever #50 mclk = ~mclk;
	task check(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task stop_test;
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Placement is issued by the core end itself right after release.
	task rst(input logic h);
		want_high = h;
		reset = 1'b1;
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task acc(input logic f, input logic [19:0] a, input target_t t, input logic flt,
		input speed_t s, input logic [7:0] c);
		logic [7:0] cs;
		speed_t sp;
		user_req = 1'b1;
		user_fetch = f;
		user_addr = a;
		@(negedge mclk);
		user_req = 1'b0;
		repeat (6)
		begin
			@(negedge mclk);
			if (mif.ack === 1'b1)
			begin
				cs = cls;
				sp = mif.speed;
			end
			if (done === 1'b1)
				break;
		end
		check(done === 1'b1 && done_target === t && done_fault === flt, "access result");
		check(cs === c, "address class");
		if (f && !flt)
			check(sp === s, "fetch speed");
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			stop_test;
		end
	end
	initial
	begin
		rst(0);
		acc(1, 20'h0003e, tgt_rom, 0, spd_slow, 8'hc1);
		acc(0, 20'h00002, tgt_rom, 0, spd_slow, 8'hc1);
		acc(0, 20'h0007f, tgt_rom, 0, spd_slow, 8'ha0);
		acc(0, 20'h00800, tgt_rom, 0, spd_slow, 8'h90);
		acc(0, 20'h0ccff, tgt_rom, 0, spd_slow, 8'h80);
		acc(1, 20'h0cd00, tgt_peripheral_ram, 0, spd_fast, 8'h80);
		acc(0, 20'h0fd20, tgt_fast_internal_ram, 0, spd_slow, 8'h88);
		acc(0, 20'h0fe3b, tgt_fast_internal_ram, 0, spd_slow, 8'h8a);
		acc(1, 20'h0fe80, tgt_fast_internal_ram, 1, spd_slow, 8'h8c);
		acc(0, 20'h0ff00, tgt_sfr, 0, spd_slow, 8'h80);
		acc(0, 20'h0ffd0, tgt_none, 1, spd_slow, 8'h80);
		acc(0, 20'h40000, tgt_none, 1, spd_slow, 8'h00);
		expand = 1'b1;
		acc(0, 20'h0ffd0, tgt_xsfr, 0, spd_slow, 8'h80);
		acc(0, 20'h40000, tgt_ext, 0, spd_slow, 8'h00);
		fast = 1'b1;
		@(negedge mclk);
		acc(1, 20'h10000, tgt_rom, 0, spd_fast, 8'h00);
		xwait = 1'b1;
		user_req = 1'b1;
		user_addr = 20'h01000;
		@(negedge mclk);
		user_req = 1'b0;
		repeat (4) @(negedge mclk);
		check(lockup === 1'b1 && mif.ack === 1'b0, "no lockup");
		xwait = 1'b0;
		fast = 1'b0;
		rst(1);
		check(mif.placed_high === 1'b1 && lockup === 1'b0, "placement");
		acc(1, 20'h0cd00, tgt_rom, 0, spd_slow, 8'h80);
		acc(0, 20'h3ffff, tgt_rom, 0, spd_slow, 8'h00);
		acc(0, 20'hfcd00, tgt_peripheral_ram, 0, spd_slow, 8'h00);
		stop_test;
	end
endmodule
